// >>> shift_store_bus_register_tb_top.sv
/*
  bench for the shift and store register: rows, then hand tests.
  assumes the controller model in ssb_ctrl_model.sv.
*/
`timescale 1ns/1ps
module shift_store_bus_register_tb_top;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic out_en_i = 1'b0;
  logic sd, sc, st, cas_rise_o, cas_fall_o;
  logic [7:0] par_data_o, par_oe_o;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  // byte sent, enable, expected drive enables
  typedef struct packed {logic [7:0] v; logic en; logic [7:0] oe;} ssb_row_t;
  ssb_row_t rows [4] = '{'{8'ha5, 1'b1, 8'hff}, '{8'h3c, 1'b0, 8'h00},
    '{8'h01, 1'b1, 8'hff}, '{8'h96, 1'b1, 8'hff}};
  always #20 clk_i = ~clk_i;
  ssb_ctrl_model ctl (.clk_i(clk_i), .ser_data_o(sd), .ser_clk_o(sc),
    .strobe_o(st));
  ssb_shift_store dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ser_data_i(sd), .ser_clk_i(sc), .strobe_i(st), .out_en_i(out_en_i),
    .par_data_o(par_data_o), .par_oe_o(par_oe_o),
    .cas_rise_o(cas_rise_o), .cas_fall_o(cas_fall_o));
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(negedge clk_i);
    sys_rst_i = 1'b0;
    foreach (rows[i]) begin
      ctl.send(rows[i].v);
      ctl.store();
      out_en_i = rows[i].en;
      repeat (5) @(negedge clk_i);
      chk(par_data_o, rows[i].v);
      chk(par_oe_o, rows[i].oe);
      chk({7'h0, cas_rise_o}, {7'h0, rows[i].v[7]});
      chk({7'h0, cas_fall_o}, {7'h0, rows[i].v[7]});
    end
    // one more bit: rising output moves first
    ctl.rise(1'b0);
    chk({7'h0, cas_rise_o}, 8'h00);
    chk({7'h0, cas_fall_o}, 8'h01);
    ctl.fall();
    chk({7'h0, cas_fall_o}, 8'h00);
    chk(par_data_o, 8'h96);
    ctl.store();
    repeat (5) @(negedge clk_i);
    chk(par_data_o, 8'h2c);
    chk(par_oe_o, 8'hff);
    // reset in mid-run: outputs float and clear
    sys_rst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk(par_oe_o, 8'h00);
    chk(par_data_o, 8'h00);
    // release: enable needs three edges to reach the drivers
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk(par_oe_o, 8'h00);
    ctl.send(8'h5a);
    ctl.store();
    repeat (5) @(negedge clk_i);
    chk(par_data_o, 8'h5a);
    chk(par_oe_o, 8'hff);
    chk({7'h0, cas_rise_o}, 8'h00);
    chk({7'h0, cas_fall_o}, 8'h00);
    wrap_up();
  end
endmodule

// >>> ssb_ctrl_model.sv
/*
  controller model: drives serial data, link clock and strobe.
  assumes the bench calls one task at a time, from a negedge.
*/
`timescale 1ns/1ps
module ssb_ctrl_model (
  // system
  input wire logic clk_i,
  // pins to the register
  output logic ser_data_o,
  output logic ser_clk_o,
  output logic strobe_o
);
  // link clock stands low outside frames
  initial begin
    ser_data_o = 1'b0;
    ser_clk_o = 1'b0;
    strobe_o = 1'b0;
  end
  // data set, then clock up; four cycles per phase
  task automatic rise(input logic b);
    @(negedge clk_i) ser_data_o = b;
    repeat (4) @(negedge clk_i);
    ser_clk_o = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask
  // clock down; data shown inverted once its hold is over
  task automatic fall();
    ser_clk_o = 1'b0;
    repeat (4) @(negedge clk_i);
    ser_data_o = ~ser_data_o;
  endtask
  // msb first so it ends in bit 7
  task automatic send(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      rise(v[i]);
      fall();
    end
  endtask
  // strobe high for six cycles
  task automatic store();
    @(negedge clk_i) strobe_o = 1'b1;
    repeat (6) @(negedge clk_i);
    strobe_o = 1'b0;
  endtask
endmodule

// >>> ssb_pkg.sv
/*
  package for the shift and store bus register: widths and reset values.
  assumes a single system clock domain; no software-visible registers.
*/
package ssb_pkg;
  localparam int unsigned SSB_STAGES = 8; // shift chain length
  localparam logic [7:0] SSB_ZERO_BYTE = 8'h00; // reset value of stages
  localparam logic SSB_ZERO_BIT = 1'b0; // reset value of single bits
  localparam logic [7:0] SSB_ALL_ON = 8'hff; // every output bit driven
  localparam logic [3:0] SSB_ZERO_SYNC = 4'h0; // reset value of sync flops
  localparam int unsigned SSB_LAST = SSB_STAGES - 1; // index of last stage
endpackage

// >>> ssb_shift_store.sv
/*
  eight-stage serial-in shift register with per-stage storage latches
  and three-state parallel outputs, plus two cascade serial outputs.
  assumes the link clock, data, strobe and enable are pins from a
  controller outside the clk_i domain; each is synchronised by two
  flops. the link clock's edges are detected on clk_i, so the link
  clock must stay well below half the 25 MHz system clock.
*/
// Operation
// - eight stages shift serial data on rising clock
// - latches follow stages while strobe high
// - enable high drives latched byte onto outputs
// - outputs high impedance while enable low
// - two cascade outputs, rising and falling edge
`timescale 1ns/1ps
module ssb_shift_store
  import ssb_pkg::*;
(
  // system
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // serial link pins
  input wire logic ser_data_i,
  input wire logic ser_clk_i,
  input wire logic strobe_i,
  input wire logic out_en_i,
  // parallel three-state outputs
  output logic [7:0] par_data_o,
  output logic [7:0] par_oe_o,
  // cascade outputs
  output logic cas_rise_o,
  output logic cas_fall_o
);

  // synchroniser flops; first stage is read only by the second
  logic [3:0] sync1_q; // first flop: data, clk, strobe, enable
  logic [3:0] sync2_q; // second flop
  logic sclk_prev_q; // previous synced link clock for edges
  logic rise_evt; // link clock rising edge
  logic fall_evt; // link clock falling edge
  logic [7:0] chain_q; // shift stages
  logic [7:0] chain_d;
  logic [7:0] store_q; // storage latches
  logic [7:0] store_d;
  logic cas_rise_q;
  logic cas_fall_q;
  logic oe_q; // registered enable view

  // two-flop synchroniser on all pin inputs
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync1_q <= SSB_ZERO_SYNC;
      sync2_q <= SSB_ZERO_SYNC;
      sclk_prev_q <= SSB_ZERO_BIT;
    end else begin
      sync1_q <= {out_en_i, strobe_i, ser_clk_i, ser_data_i};
      sync2_q <= sync1_q;
      sclk_prev_q <= sync2_q[1];
    end
  end

  // edge detection on the synchronised link clock
  assign rise_evt = sync2_q[1] & ~sclk_prev_q;
  assign fall_evt = ~sync2_q[1] & sclk_prev_q;

  // next chain value: new bit into stage 0, others move up
  always_comb begin
    chain_d = chain_q;
    if (rise_evt) begin
      chain_d = {chain_q[SSB_LAST-1:0], sync2_q[0]};
    end
  end

  // shift chain register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      chain_q <= SSB_ZERO_BYTE;
    end else begin
      chain_q <= chain_d;
    end
  end

  // latches are transparent while strobe high, so follow chain_d
  always_comb begin
    store_d = store_q;
    if (sync2_q[2]) begin
      store_d = chain_d;
    end
  end

  // storage latch register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      store_q <= SSB_ZERO_BYTE;
    end else begin
      store_q <= store_d;
    end
  end

  // cascade outputs from the last stage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cas_rise_q <= SSB_ZERO_BIT;
      cas_fall_q <= SSB_ZERO_BIT;
    end else begin
      if (rise_evt) begin
        cas_rise_q <= chain_d[SSB_LAST];
      end
      if (fall_evt) begin
        cas_fall_q <= chain_q[SSB_LAST];
      end
    end
  end

  // enable view, registered so outputs come from flops
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      oe_q <= SSB_ZERO_BIT;
    end else begin
      oe_q <= sync2_q[3];
    end
  end

  // parallel outputs: data always shows latches, enable gates drive
  assign par_data_o = store_q;
  // one drive enable per output bit, all from the one enable flop
  for (genvar g = 0; g < SSB_STAGES; g++) begin : g_oe
    assign par_oe_o[g] = oe_q;
  end
  assign cas_rise_o = cas_rise_q;
  assign cas_fall_o = cas_fall_q;

  // shift moves stage 0 to stage 1 on a rising event
  a_shift_moves: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    rise_evt |=> chain_q[SSB_LAST:1] == $past(chain_q[SSB_LAST-1:0]))
    else $error("shift chain did not advance");
  // new serial bit enters stage 0
  a_shift_input: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    rise_evt |=> chain_q[0] == $past(sync2_q[0]))
    else $error("serial bit not loaded");
  // chain holds without a rising event
  a_shift_hold: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    !rise_evt |=> $stable(chain_q))
    else $error("chain changed without edge");
  // latches track chain while strobe high
  a_latch_follow: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    sync2_q[2] |=> store_q == chain_q)
    else $error("latch not following chain");
  // latches hold while strobe low
  a_latch_hold: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    !sync2_q[2] |=> $stable(store_q))
    else $error("latch changed with strobe low");
  // enabled outputs drive latched byte
  a_out_drive: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    sync2_q[3] |=> (par_oe_o == SSB_ALL_ON) && (par_data_o == store_q))
    else $error("outputs not driven when enabled");
  // disabled outputs float
  a_out_float: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    !sync2_q[3] |=> par_oe_o == SSB_ZERO_BYTE)
    else $error("outputs driven when disabled");
  // rising cascade equals last stage after a rising event
  a_cas_rise: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    rise_evt |=> cas_rise_o == chain_q[SSB_LAST])
    else $error("rising cascade mismatch");
  // falling cascade takes the last stage on a falling event
  a_cas_fall: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    fall_evt |=> cas_fall_o == chain_q[SSB_LAST])
    else $error("falling cascade mismatch");
  // a rising event lasts one system clock only
  a_rise_single: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    rise_evt |=> !rise_evt)
    else $error("rising event held too long");
  // a falling event lasts one system clock only
  a_fall_single: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    fall_evt |=> !fall_evt)
    else $error("falling event held too long");
  // the two link clock edges never coincide
  a_edge_apart: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    !(rise_evt && fall_evt))
    else $error("rising and falling events together");
  // rising cascade moves only on a rising event
  a_cas_rise_hold: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    !rise_evt |=> $stable(cas_rise_o))
    else $error("rising cascade changed without edge");
  // falling cascade moves only on a falling event
  a_cas_fall_hold: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    !fall_evt |=> $stable(cas_fall_o))
    else $error("falling cascade changed without edge");
  // rising cascade always mirrors the last stage
  a_cas_rise_track: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    cas_rise_o == chain_q[SSB_LAST])
    else $error("rising cascade not on last stage");
  // after a falling event both cascades agree
  a_cas_aligned: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    fall_evt |=> cas_fall_o == cas_rise_o)
    else $error("cascades disagree after falling edge");
  // drive enables are all on or all off
  a_oe_uniform: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (par_oe_o == SSB_ALL_ON) || (par_oe_o == SSB_ZERO_BYTE))
    else $error("drive enables split");
  // drive enables move only when the enable pin moved
  a_oe_hold: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    $stable(sync2_q[3]) |=> $stable(par_oe_o))
    else $error("drive enables changed on their own");
  // reset leaves every output bit floating
  a_reset_float: assert property (@(posedge clk_i)
    sys_rst_i |=> par_oe_o == SSB_ZERO_BYTE)
    else $error("outputs driven after reset");
  // reset clears the chain and the latches
  a_reset_clear: assert property (@(posedge clk_i)
    sys_rst_i |=> (chain_q == SSB_ZERO_BYTE) && (store_q == SSB_ZERO_BYTE))
    else $error("chain or latches not cleared by reset");

endmodule
